/* File: logic/can_global_status_interrupt.sv */
// Global status, protocol error flags, error counters and interrupt enables
`timescale 1ns/100ps
// Operation
// - Overload flag high while own overload frame sent
// - Transmitter busy while sending any frame or ack
// - Transmitter busy in interframe when frame pending
// - Receiver busy while acquiring or monitoring frame
// - Enabled flag shows true, lagging controller state
// - Bus-off and error-passive follow fault confinement
// - Busy, overload, enable flags never interrupt
// - Bit 7 mirrors the interrupt request
// - Timer wrap to zero sets flag
// - Timer wrap interrupts only with core enable
// - Buffer full sets sticky overrun flag
// - More than five equal bits sets stuff error
// - CRC mismatch over received frame sets flag
// - Fixed-form field violation sets form error
// - Missing dominant ack on transmit sets flag
// - Protocol error flags interrupt and stay set
// - Transmit error count readable, resets to zero
// - Receive error count readable, resets to zero
// - Enable bits 5 and 4 gate rx, tx
// - Bits 3,2,1 gate object, buffer, protocol errors
// - Controller clock runs only while enabled
// - Enabled flag rises three clocks after enable
module can_global_status_interrupt #(
  parameter int TIMER_W = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  output logic [7:0] sfrRdData,
  input wire logic controllerRunControl,
  input wire logic overloadSending,
  input wire logic txFrameActive,
  input wire logic interframeSpace,
  input wire logic txFramePending,
  input wire logic rxFrameActive,
  input wire logic [TIMER_W-1:0] canTimer,
  input wire logic bufferFull,
  input wire logic rxBitValid,
  input wire logic rxBit,
  input wire logic crcInit,
  input wire logic crcDataPhase,
  input wire logic crcFieldPhase,
  input wire logic crcCheck,
  input wire logic fixedFormSlot,
  input wire logic ackSlot,
  input wire logic transmitting,
  input wire logic txErrEvent,
  input wire logic rxErrEvent,
  input wire logic txOkEvent,
  input wire logic rxOkEvent,
  input wire logic busOffRecovered,
  input wire logic rxDoneIrq,
  input wire logic txDoneIrq,
  input wire logic objErrIrq,
  input wire logic timer_wrap_irq_enable,
  output logic canIrq,
  output logic controllerClkRun
);
  import can_gsi_pkg::*;

  if (TIMER_W != 16) begin : g_bad_timer
    $error("can_global_status_interrupt: TIMER_W must be 16");
  end

  logic [7:0] tec, rec;
  logic busOffState, errorPassiveState;

  can_fault_confinement u_fc (
    .core_clk(core_clk),
    .srst(srst),
    .txErrEvent(txErrEvent),
    .rxErrEvent(rxErrEvent),
    .txOkEvent(txOkEvent),
    .rxOkEvent(rxOkEvent),
    .busOffRecovered(busOffRecovered),
    .txErrorCount(tec),
    .rxErrorCount(rec),
    .busOffState(busOffState),
    .errorPassiveState(errorPassiveState)
  );

  // Status and enable state
  logic [7:0] status_r, status_nxt;
  logic [7:0] ienable_r, ienable_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic irq_r, irq_nxt;
  logic clkRun_r, clkRun_nxt;
  run_state_t run_r, run_nxt;
  logic [1:0] runCnt_r, runCnt_nxt;
  logic [TIMER_W-1:0] timerPrev_r;
  logic [2:0] runLen_r, runLen_nxt;
  logic lastBit_r, lastBit_nxt;
  logic [14:0] crcCalc_r, crcCalc_nxt, crcRecv_r, crcRecv_nxt;
  logic [5:0] hwSet;
  logic flagsWr;

  // Controller run sequencing
  always_comb begin
    run_nxt = run_r;
    runCnt_nxt = runCnt_r;
    clkRun_nxt = controllerRunControl;
    case (run_r)
      RUN_STANDBY: begin
        runCnt_nxt = 2'h0;
        if (controllerRunControl) begin
          run_nxt = RUN_STARTING;
          runCnt_nxt = 2'h1;
        end
      end
      RUN_STARTING: begin
        if (!controllerRunControl) begin
          run_nxt = RUN_STANDBY;
        end else if (runCnt_r == ENABLE_DELAY) begin
          run_nxt = RUN_ACTIVE;
        end else begin
          runCnt_nxt = runCnt_r + 2'h1;
        end
      end
      RUN_ACTIVE: begin
        if (!controllerRunControl) begin
          run_nxt = RUN_STANDBY;
        end
      end
      default: run_nxt = RUN_STANDBY;
    endcase
  end

  // Protocol checks: stuff run length and CRC
  always_comb begin
    runLen_nxt = runLen_r;
    lastBit_nxt = lastBit_r;
    crcCalc_nxt = crcCalc_r;
    crcRecv_nxt = crcRecv_r;
    if (crcInit) begin
      runLen_nxt = 3'h0;
      crcCalc_nxt = 15'h0000;
      crcRecv_nxt = 15'h0000;
    end else if (rxBitValid) begin
      lastBit_nxt = rxBit;
      if (runLen_r != 3'h0 && rxBit == lastBit_r) begin
        runLen_nxt = (runLen_r == 3'h7) ? 3'h7 : runLen_r + 3'h1;
      end else begin
        runLen_nxt = 3'h1;
      end
      if (crcDataPhase) begin
        crcCalc_nxt = {crcCalc_r[13:0], 1'b0} ^ ((rxBit ^ crcCalc_r[14]) ? CRC_POLY : 15'h0000);
      end
      if (crcFieldPhase) begin
        crcRecv_nxt = {crcRecv_r[13:0], rxBit};
      end
    end
  end

  // Hardware event sets and flag register
  always_comb begin
    hwSet = 6'h00;
    hwSet[FLG_TIMER_WRAP] = (timerPrev_r == TIMER_MAX) && (canTimer == TIMER_ZERO);
    hwSet[FLG_BUFFER_FULL] = bufferFull;
    hwSet[FLG_STUFF] = rxBitValid && runLen_nxt > STUFF_RUN_LIMIT;
    hwSet[FLG_CRC] = crcCheck && (crcCalc_r != crcRecv_r);
    hwSet[FLG_FORM] = fixedFormSlot && rxBitValid && !rxBit;
    hwSet[FLG_ACK] = ackSlot && transmitting && rxBitValid && rxBit;
    flagsWr = sfrWr && sfrAddr == ADDR_GENERAL_IRQ_FLAGS;
    flags_nxt = flags_r;
    if (flagsWr) begin
      flags_nxt = flags_r & (sfrWrData | ~FLAGS_WRITE_MASK);
    end
    flags_nxt[5:0] = flags_nxt[5:0] | hwSet;
    flags_nxt[FLG_ANY_IRQ] = irq_nxt;
    flags_nxt[6] = 1'b0;
  end

  // Interrupt request from enabled pending sources
  always_comb begin
    irq_nxt = (rxDoneIrq && ienable_r[IE_RX])
      || (txDoneIrq && ienable_r[IE_TX])
      || (objErrIrq && ienable_r[IE_OBJ_ERR])
      || (flags_r[FLG_BUFFER_FULL] && ienable_r[IE_BUFFER])
      || ((|flags_r[FLG_STUFF:FLG_ACK]) && ienable_r[IE_PROT_ERR])
      || (flags_r[FLG_TIMER_WRAP] && timer_wrap_irq_enable);
  end

  // Status, enable register and read port
  always_comb begin
    status_nxt = RESET_BYTE;
    status_nxt[STA_OVERLOAD] = overloadSending;
    status_nxt[STA_TX_BUSY] = txFrameActive || (interframeSpace && txFramePending);
    status_nxt[STA_RX_BUSY] = rxFrameActive;
    status_nxt[STA_ENABLED] = run_nxt == RUN_ACTIVE;
    status_nxt[STA_BUS_OFF] = busOffState;
    status_nxt[STA_ERR_PASSIVE] = errorPassiveState;
    ienable_nxt = ienable_r;
    if (sfrWr && sfrAddr == ADDR_GENERAL_IRQ_ENABLE) begin
      ienable_nxt = sfrWrData & ENABLE_WRITE_MASK;
    end
    rdData_nxt = rdData_r;
    if (sfrRd) begin
      case (sfrAddr)
        ADDR_GENERAL_IRQ_FLAGS: rdData_nxt = flags_r;
        ADDR_TX_ERROR_COUNT: rdData_nxt = tec;
        ADDR_RX_ERROR_COUNT: rdData_nxt = rec;
        ADDR_GENERAL_STATUS: rdData_nxt = status_r;
        ADDR_GENERAL_IRQ_ENABLE: rdData_nxt = ienable_r;
        default: rdData_nxt = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      run_r <= RUN_STANDBY;
      runCnt_r <= 2'h0;
      clkRun_r <= 1'b0;
      runLen_r <= 3'h0;
      lastBit_r <= 1'b1;
      crcCalc_r <= 15'h0000;
      crcRecv_r <= 15'h0000;
      timerPrev_r <= '0;
      flags_r <= RESET_BYTE;
      irq_r <= 1'b0;
      status_r <= RESET_BYTE;
      ienable_r <= RESET_BYTE;
      rdData_r <= RESET_BYTE;
    end else begin
      run_r <= run_nxt;
      runCnt_r <= runCnt_nxt;
      clkRun_r <= clkRun_nxt;
      runLen_r <= runLen_nxt;
      lastBit_r <= lastBit_nxt;
      crcCalc_r <= crcCalc_nxt;
      crcRecv_r <= crcRecv_nxt;
      timerPrev_r <= canTimer;
      flags_r <= flags_nxt;
      irq_r <= irq_nxt;
      status_r <= status_nxt;
      ienable_r <= ienable_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign sfrRdData = rdData_r;
  assign canIrq = irq_r;
  assign controllerClkRun = clkRun_r;

  // Checks
  a_overload_mirror: assert property (@(posedge core_clk) disable iff (srst)
    overloadSending |=> status_r[STA_OVERLOAD]) else $error("overload flag missing");
  a_tx_busy_frame: assert property (@(posedge core_clk) disable iff (srst)
    txFrameActive |=> status_r[STA_TX_BUSY]) else $error("tx busy missing in frame");
  a_tx_busy_ifs: assert property (@(posedge core_clk) disable iff (srst)
    interframeSpace && txFramePending |=> status_r[STA_TX_BUSY])
    else $error("tx busy missing in interframe");
  a_rx_busy: assert property (@(posedge core_clk) disable iff (srst)
    rxFrameActive |=> status_r[STA_RX_BUSY]) else $error("rx busy missing");
  a_enable_delay: assert property (@(posedge core_clk) disable iff (srst)
    $rose(controllerRunControl) && run_r == RUN_STANDBY |=>
      !status_r[STA_ENABLED] ##1 !status_r[STA_ENABLED])
    else $error("enabled flag too early");
  a_enable_rise: assert property (@(posedge core_clk) disable iff (srst)
    !controllerRunControl ##1 controllerRunControl [*4] |-> status_r[STA_ENABLED])
    else $error("enabled flag late");
  a_irq_image: assert property (@(posedge core_clk) disable iff (srst)
    flags_r[FLG_ANY_IRQ] == irq_r) else $error("irq image differs from request");
  a_timer_wrap: assert property (@(posedge core_clk) disable iff (srst)
    canTimer == TIMER_MAX ##1 canTimer == TIMER_ZERO |=> flags_r[FLG_TIMER_WRAP])
    else $error("timer wrap not flagged");
  a_wrap_gate: assert property (@(posedge core_clk) disable iff (srst)
    flags_r[FLG_TIMER_WRAP] && timer_wrap_irq_enable |=> irq_r)
    else $error("timer wrap irq missing");
  a_set_beats_clear: assert property (@(posedge core_clk) disable iff (srst)
    flagsWr && bufferFull |=> flags_r[FLG_BUFFER_FULL])
    else $error("set lost to clear");
  a_prot_sticky: assert property (@(posedge core_clk) disable iff (srst)
    flags_r[FLG_ACK] && !flagsWr |=> flags_r[FLG_ACK])
    else $error("ack error flag dropped");
  a_rx_gate: assert property (@(posedge core_clk) disable iff (srst)
    !ienable_r[IE_RX] && !ienable_r[IE_TX] && !ienable_r[IE_OBJ_ERR] && !ienable_r[IE_BUFFER]
      && !ienable_r[IE_PROT_ERR] && !timer_wrap_irq_enable |=> !irq_r)
    else $error("irq without enable");
  a_clk_run: assert property (@(posedge core_clk) disable iff (srst)
    controllerRunControl |=> controllerClkRun) else $error("clock not run");
endmodule : can_global_status_interrupt

/* File: inc/can_gsi_pkg.sv */
// Register map, field positions and constants of the CAN global status block
package can_gsi_pkg;
  localparam logic [7:0] ADDR_GENERAL_IRQ_FLAGS = 8'h9b;
  localparam logic [7:0] ADDR_TX_ERROR_COUNT = 8'h9c;
  localparam logic [7:0] ADDR_RX_ERROR_COUNT = 8'h9d;
  localparam logic [7:0] ADDR_GENERAL_STATUS = 8'haa;
  localparam logic [7:0] ADDR_GENERAL_IRQ_ENABLE = 8'hc1;
  // General status fields
  localparam int STA_OVERLOAD = 6;
  localparam int STA_TX_BUSY = 4;
  localparam int STA_RX_BUSY = 3;
  localparam int STA_ENABLED = 2;
  localparam int STA_BUS_OFF = 1;
  localparam int STA_ERR_PASSIVE = 0;
  // Interrupt flag fields
  localparam int FLG_ANY_IRQ = 7;
  localparam int FLG_TIMER_WRAP = 5;
  localparam int FLG_BUFFER_FULL = 4;
  localparam int FLG_STUFF = 3;
  localparam int FLG_CRC = 2;
  localparam int FLG_FORM = 1;
  localparam int FLG_ACK = 0;
  // Interrupt enable fields
  localparam int IE_RX = 5;
  localparam int IE_TX = 4;
  localparam int IE_OBJ_ERR = 3;
  localparam int IE_BUFFER = 2;
  localparam int IE_PROT_ERR = 1;
  localparam logic [7:0] FLAGS_WRITE_MASK = 8'h3f;
  localparam logic [7:0] ENABLE_WRITE_MASK = 8'h3e;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] TIMER_MAX = 16'hffff;
  localparam logic [15:0] TIMER_ZERO = 16'h0000;
  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic [2:0] STUFF_RUN_LIMIT = 3'h5;
  localparam logic [1:0] ENABLE_DELAY = 2'h2;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h0ff;
  localparam logic [8:0] TX_ERR_STEP = 9'h008;
  typedef enum logic [1:0] {RUN_STANDBY, RUN_STARTING, RUN_ACTIVE} run_state_t;
endpackage : can_gsi_pkg

/* File: logic/can_fault_confinement.sv */
// Transmit and receive error counters with error-passive and bus-off state
`timescale 1ns/100ps
module can_fault_confinement (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic txErrEvent,
  input wire logic rxErrEvent,
  input wire logic txOkEvent,
  input wire logic rxOkEvent,
  input wire logic busOffRecovered,
  output logic [7:0] txErrorCount,
  output logic [7:0] rxErrorCount,
  output logic busOffState,
  output logic errorPassiveState
);
  import can_gsi_pkg::*;
  logic [8:0] tec_r, tec_nxt, rec_r, rec_nxt;
  logic busOff_r, busOff_nxt;

  always_comb begin
    tec_nxt = tec_r;
    rec_nxt = rec_r;
    busOff_nxt = busOff_r;
    if (busOff_r) begin
      if (busOffRecovered) begin
        busOff_nxt = 1'b0;
        tec_nxt = 9'h000;
        rec_nxt = 9'h000;
      end
    end else begin
      if (txErrEvent) begin
        tec_nxt = tec_r + TX_ERR_STEP;
      end else if (txOkEvent && tec_r != 9'h000) begin
        tec_nxt = tec_r - 9'h001;
      end
      if (rxErrEvent && rec_r <= PASSIVE_LIMIT) begin
        rec_nxt = rec_r + 9'h001;
      end else if (rxOkEvent && rec_r != 9'h000) begin
        rec_nxt = (rec_r > PASSIVE_LIMIT) ? PASSIVE_LIMIT - 9'h00a : rec_r - 9'h001;
      end
      if (tec_nxt > BUS_OFF_LIMIT) begin
        busOff_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tec_r <= 9'h000;
      rec_r <= 9'h000;
      busOff_r <= 1'b0;
    end else begin
      tec_r <= tec_nxt;
      rec_r <= rec_nxt;
      busOff_r <= busOff_nxt;
    end
  end

  assign txErrorCount = (tec_r > BUS_OFF_LIMIT) ? 8'hff : tec_r[7:0];
  assign rxErrorCount = rec_r[7:0];
  assign busOffState = busOff_r;
  assign errorPassiveState = !busOff_r && (tec_r > PASSIVE_LIMIT || rec_r > PASSIVE_LIMIT);
endmodule : can_fault_confinement

/* File: test/can_bus_node_model.sv */
// Bit-level model of the engine side: bus bits, frame marks and ack slots
`timescale 1ns/100ps
module can_bus_node_model (
  input wire logic core_clk,
  output logic rxBitValid,
  output logic rxBit,
  output logic crcInit,
  output logic crcDataPhase,
  output logic crcFieldPhase,
  output logic crcCheck,
  output logic fixedFormSlot,
  output logic ackSlot,
  output logic transmitting
);
  initial begin
    {rxBitValid, crcInit, crcDataPhase, crcFieldPhase, crcCheck} = '0;
    {fixedFormSlot, ackSlot, transmitting} = '0;
    rxBit = 1'b1;
  end
  // Kind 0 plain, 1 fixed form, 2 own ack slot, 3 CRC field, 4 CRC covered data
  task automatic sendBit(input logic v, input int kind);
    rxBitValid = 1'b1;
    rxBit = v;
    fixedFormSlot = (kind == 1);
    ackSlot = (kind == 2);
    transmitting = (kind == 2);
    crcFieldPhase = (kind == 3);
    crcDataPhase = (kind == 4);
    @(posedge core_clk);
    #1;
    {rxBitValid, fixedFormSlot, ackSlot, transmitting, crcFieldPhase, crcDataPhase} = '0;
    rxBit = ~v;
  endtask : sendBit
  // Start of frame clears CRC and run state; otherwise a CRC compare
  task automatic mark(input logic start);
    crcInit = start;
    crcCheck = ~start;
    @(posedge core_clk);
    #1;
    crcInit = 1'b0;
    crcCheck = 1'b0;
  endtask : mark
endmodule : can_bus_node_model

/* File: test/can_global_status_interrupt_tb.sv */
// Self-checking bench of the CAN global status and interrupt block
`timescale 1ns/100ps
module can_global_status_interrupt_tb;
  import can_gsi_pkg::*;
  typedef struct {logic [4:0] eng; logic [7:0] sta;} row_t;
  logic core_clk, srst, sfrWr, sfrRd, runCtl, bufferFull, timerWrapIe;
  logic canIrq, controllerClkRun, rxBitValid, rxBit, crcInit, crcFieldPhase, crcCheck;
  logic fixedFormSlot, ackSlot, transmitting, crcDataPhase;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, d;
  logic [15:0] canTimer;
  logic [4:0] eng, evs;
  logic [2:0] srcs;
  int miscompares = 0;
  int nCompared = 0;
  int cycles = 0;
  row_t rows[5] = '{'{5'b10000, 8'h40}, '{5'b01000, 8'h10}, '{5'b00110, 8'h10},
    '{5'b00100, 8'h00}, '{5'b00001, 8'h08}};
  logic [7:0] addrs[6] = '{8'h9b, 8'h9c, 8'h9d, 8'haa, 8'hc1, 8'h9e};
  can_global_status_interrupt DUT (.core_clk(core_clk), .srst(srst),
    .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrRdData(sfrRdData), .controllerRunControl(runCtl), .overloadSending(eng[4]),
    .txFrameActive(eng[3]), .interframeSpace(eng[2]), .txFramePending(eng[1]),
    .rxFrameActive(eng[0]), .canTimer(canTimer), .bufferFull(bufferFull),
    .rxBitValid(rxBitValid), .rxBit(rxBit), .crcInit(crcInit), .crcDataPhase(crcDataPhase),
    .crcFieldPhase(crcFieldPhase), .crcCheck(crcCheck), .fixedFormSlot(fixedFormSlot),
    .ackSlot(ackSlot), .transmitting(transmitting), .txErrEvent(evs[0]),
    .rxErrEvent(evs[1]), .txOkEvent(evs[2]), .rxOkEvent(evs[3]),
    .busOffRecovered(evs[4]), .rxDoneIrq(srcs[2]), .txDoneIrq(srcs[1]),
    .objErrIrq(srcs[0]), .timer_wrap_irq_enable(timerWrapIe), .canIrq(canIrq),
    .controllerClkRun(controllerClkRun));
  can_bus_node_model node (.core_clk(core_clk), .rxBitValid(rxBitValid), .rxBit(rxBit),
    .crcInit(crcInit), .crcDataPhase(crcDataPhase), .crcFieldPhase(crcFieldPhase),
    .crcCheck(crcCheck),
    .fixedFormSlot(fixedFormSlot), .ackSlot(ackSlot), .transmitting(transmitting));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    {sfrWr, sfrAddr, sfrWrData} = {1'b1, a, v};
    tick();
    sfrWr = 1'b0;
    tick();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    tick();
    {sfrRd, sfrAddr} = {1'b1, a};
    tick();
    sfrRd = 1'b0;
    d = sfrRdData;
  endtask : rd
  task automatic ev(input int idx, input int n);
    repeat (n) begin
      evs[idx] = 1'b1;
      tick();
      evs = '0;
      tick();
    end
  endtask : ev
  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t register got %h expected %h", $time, got, exp);
    end
  endtask : chkReg
  task automatic chkPin(input logic got, input logic exp);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t output got %b expected %b", $time, got, exp);
    end
  endtask : chkPin
  task automatic give_verdict;
    if (miscompares == 0 && nCompared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    {srst, sfrWr, sfrRd, runCtl, bufferFull, timerWrapIe} = 6'b100000;
    {sfrAddr, sfrWrData, canTimer, eng, evs, srcs} = '0;
    repeat (3) tick();
    srst = 1'b0;
    foreach (addrs[i]) begin
      rd(addrs[i]);
      chkReg(d, RESET_BYTE);
    end
    wr(ADDR_GENERAL_IRQ_ENABLE, ENABLE_WRITE_MASK);
    timerWrapIe = 1'b1;
    rd(ADDR_GENERAL_IRQ_ENABLE);
    chkReg(d, 8'h3e);
    foreach (rows[i]) begin
      eng = rows[i].eng;
      rd(ADDR_GENERAL_STATUS);
      chkReg(d, rows[i].sta);
      chkPin(canIrq, 1'b0);
    end
    eng = '0;
    wr(ADDR_GENERAL_IRQ_ENABLE, 8'h00);
    node.mark(1'b1);
    repeat (5) node.sendBit(1'b0, 0);
    node.sendBit(1'b1, 0);
    rd(ADDR_GENERAL_IRQ_FLAGS);
    chkReg(d, 8'h00);
    repeat (6) node.sendBit(1'b0, 0);
    node.sendBit(1'b0, 2);
    node.sendBit(1'b1, 1);
    rd(ADDR_GENERAL_IRQ_FLAGS);
    chkReg(d, 8'h08);
    node.sendBit(1'b1, 2);
    node.sendBit(1'b0, 1);
    node.mark(1'b1);
    node.mark(1'b0);
    rd(ADDR_GENERAL_IRQ_FLAGS);
    chkReg(d, 8'h0b);
    node.mark(1'b1);
    node.sendBit(1'b1, 4);
    for (int i = 14; i >= 0; i--) begin
      node.sendBit(CRC_POLY[i], 3);
    end
    node.mark(1'b0);
    rd(ADDR_GENERAL_IRQ_FLAGS);
    chkReg(d, 8'h0b);
    node.mark(1'b1);
    node.sendBit(1'b1, 3);
    node.mark(1'b0);
    rd(ADDR_GENERAL_IRQ_FLAGS);
    chkReg(d, 8'h0f);
    wr(ADDR_GENERAL_IRQ_ENABLE, 8'h02);
    chkPin(canIrq, 1'b1);
    rd(ADDR_GENERAL_IRQ_FLAGS);
    chkReg(d, 8'h8f);
    wr(ADDR_GENERAL_IRQ_FLAGS, 8'hf7);
    rd(ADDR_GENERAL_IRQ_FLAGS);
    chkReg(d, 8'h87);
    wr(ADDR_GENERAL_IRQ_FLAGS, 8'h00);
    rd(ADDR_GENERAL_IRQ_FLAGS);
    chkReg(d, 8'h00);
    timerWrapIe = 1'b0;
    canTimer = 16'hfffe;
    tick();
    canTimer = TIMER_MAX;
    tick();
    canTimer = TIMER_ZERO;
    rd(ADDR_GENERAL_IRQ_FLAGS);
    chkReg(d, 8'h20);
    chkPin(canIrq, 1'b0);
    timerWrapIe = 1'b1;
    repeat (2) tick();
    chkPin(canIrq, 1'b1);
    wr(ADDR_GENERAL_IRQ_FLAGS, 8'h1f);
    chkPin(canIrq, 1'b0);
    wr(ADDR_GENERAL_IRQ_ENABLE, 8'h04);
    bufferFull = 1'b1;
    wr(ADDR_GENERAL_IRQ_FLAGS, 8'h00);
    rd(ADDR_GENERAL_IRQ_FLAGS);
    chkReg(d, 8'h90);
    bufferFull = 1'b0;
    rd(ADDR_GENERAL_IRQ_FLAGS);
    chkReg(d, 8'h90);
    wr(ADDR_GENERAL_IRQ_FLAGS, 8'h00);
    for (int i = 3; i < 6; i++) begin
      wr(ADDR_GENERAL_IRQ_ENABLE, 8'h00);
      srcs = 3'b001 << (i - 3);
      repeat (2) tick();
      chkPin(canIrq, 1'b0);
      wr(ADDR_GENERAL_IRQ_ENABLE, 8'h01 << i);
      chkPin(canIrq, 1'b1);
      srcs = '0;
    end
    runCtl = 1'b1;
    {sfrRd, sfrAddr} = {1'b1, ADDR_GENERAL_STATUS};
    tick();
    sfrRd = 1'b0;
    chkReg(sfrRdData, 8'h00);
    chkPin(controllerClkRun, 1'b1);
    repeat (3) tick();
    rd(ADDR_GENERAL_STATUS);
    chkReg(d, 8'h04);
    runCtl = 1'b0;
    repeat (5) tick();
    chkPin(controllerClkRun, 1'b0);
    ev(0, 16);
    rd(ADDR_TX_ERROR_COUNT);
    chkReg(d, 8'h80);
    rd(ADDR_GENERAL_STATUS);
    chkReg(d, 8'h01);
    ev(0, 16);
    rd(ADDR_GENERAL_STATUS);
    chkReg(d, 8'h02);
    rd(ADDR_TX_ERROR_COUNT);
    chkReg(d, 8'hff);
    ev(4, 1);
    wr(ADDR_TX_ERROR_COUNT, 8'hff);
    rd(ADDR_TX_ERROR_COUNT);
    chkReg(d, 8'h00);
    ev(1, 3);
    ev(3, 1);
    ev(2, 1);
    rd(ADDR_RX_ERROR_COUNT);
    chkReg(d, 8'h02);
    srst = 1'b1;
    repeat (3) tick();
    srst = 1'b0;
    rd(ADDR_RX_ERROR_COUNT);
    chkReg(d, 8'h00);
    give_verdict();
  end
endmodule : can_global_status_interrupt_tb
